// ---- logic/rpt_dev_end.sv ----
// Timestamp capture end: stamps frames at the capture plane.
//
// How it works
// - Partner supplies 80-bit time, capture-clock retimed.
// - Stamp valid on packet's first stream cycle.
// - Latch time when SOP crosses capture plane.
// - Every received frame is stamped, unfiltered.
// - Marked transmit frames stamped, returned with tag; a mark made while one waits is dropped and sets txDropped.
// - FEC sits line-side of the capture plane.
// - Resolution is one capture clock period.
// - Report SOP lane and per-lane fill levels.
// - Partner adds fill difference times clock period.
// - Reference is stamping lane, other is SOP lane.
// - Partner should time-average each fill level.
// - Partner converts fill cycles into time units.
// - Corrected stamp stays in step with packet.
// - Same scheme for two or four lanes.
// - Report logical lane behind each status position.
module rpt_dev_end #(
  parameter int LANES = rpt_pkg::LANES_50G,
  parameter int DLY = rpt_pkg::STREAM_DLY
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link to the user packet logic
  rpt_link_if.dev lnk,
  // Receive capture plane
  input wire logic lineRxSop,
  input wire logic [rpt_pkg::LANE_W-1:0] lineRxLane,
  input wire logic [rpt_pkg::MAX_LANES-1:0][rpt_pkg::FILL_W-1:0] lineFill,
  input wire logic [rpt_pkg::MAX_LANES-1:0][rpt_pkg::LANE_W-1:0] linePinMap,
  // Transmit capture plane
  input wire logic lineTxSop,
  output logic txDropped
);

  typedef struct packed
  {
    logic [DLY-1:0] sopPipe;
    logic [DLY-1:0][rpt_pkg::TIME_W-1:0] stampPipe;
    logic [DLY-1:0][rpt_pkg::LANE_W-1:0] lanePipe;
    logic [rpt_pkg::MAX_LANES-1:0][rpt_pkg::FILL_W-1:0] fill;
    logic [rpt_pkg::MAX_LANES-1:0][rpt_pkg::LANE_W-1:0] pinMap;
    logic mapError;
    rpt_pkg::rpt_tx_state_type txState;
    logic [rpt_pkg::TAG_W-1:0] txPendTag;
    logic txStampValid;
    logic [rpt_pkg::TIME_W-1:0] txStamp;
    logic [rpt_pkg::TAG_W-1:0] txStampTag;
    logic txDropped;
  } rpt_dev_state_type;

  rpt_dev_state_type state_r;
  rpt_dev_state_type state_nxt;

  // A lane map is bad when a position names an absent lane or when two
  // positions name the same lane, which means a lane was never found.
  function automatic logic rpt_map_bad(
    input logic [rpt_pkg::MAX_LANES-1:0][rpt_pkg::LANE_W-1:0] map
  );
    logic [rpt_pkg::MAX_LANES-1:0] seen;
    logic bad;
    seen = '0;
    bad = 1'b0;
    for (int i = 0; i < LANES; i++)
    begin
      if (int'(map[i]) >= LANES || seen[map[i]])
      begin
        bad = 1'b1;
      end
      seen[map[i]] = 1'b1;
    end
    return bad;
  endfunction

  always_comb
  begin
    state_nxt = state_r;

    // Line-side FEC decode
    // The SOP arrives here already decoded, so FEC on or off leaves
    // the capture point where it is and only adds loop latency.
    // Latch at crossing
    // One-clock resolution
    // The time input is sampled on the same clock that sees the SOP,
    // so a stamp can be off by up to one clock period.
    for (int i = DLY - 1; i > 0; i--)
    begin
      state_nxt.sopPipe[i] = state_r.sopPipe[i-1];
      state_nxt.stampPipe[i] = state_r.stampPipe[i-1];
      state_nxt.lanePipe[i] = state_r.lanePipe[i-1];
    end
    state_nxt.sopPipe[0] = lineRxSop;
    if (lineRxSop)
    begin
      state_nxt.stampPipe[0] = lnk.sysTime;
      state_nxt.lanePipe[0] = lineRxLane;
    end

    for (int i = 0; i < rpt_pkg::MAX_LANES; i++)
    begin
      if (i < LANES)
      begin
        state_nxt.fill[i] = lineFill[i];
        state_nxt.pinMap[i] = linePinMap[i];
      end
      else
      begin
        state_nxt.fill[i] = '0;
        state_nxt.pinMap[i] = '0;
      end
    end
    state_nxt.mapError = rpt_map_bad(linePinMap);

    // Marked transmit stamping
    // Only one marked frame may wait for its crossing at a time; this
    // keeps the tag store to one word at the cost of a busy window.
    state_nxt.txStampValid = 1'b0;
    unique case (state_r.txState)
      rpt_pkg::TX_IDLE:
      begin
        if (lnk.txSop && lnk.txPtp)
        begin
          state_nxt.txPendTag = lnk.txTag;
          state_nxt.txState = rpt_pkg::TX_PEND;
        end
      end
      rpt_pkg::TX_PEND:
      begin
        if (lnk.txSop && lnk.txPtp)
        begin
          state_nxt.txDropped = 1'b1;
        end
        if (lineTxSop)
        begin
          state_nxt.txStamp = lnk.sysTime;
          state_nxt.txStampTag = state_r.txPendTag;
          state_nxt.txStampValid = 1'b1;
          state_nxt.txState = rpt_pkg::TX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Stamp held otherwise
  // The stamp register only reloads on an SOP, so outside the first
  // cycle it shows a stale stamp that the user must not take.
  assign lnk.rxSop = state_r.sopPipe[DLY-1];
  assign lnk.rxStamp = state_r.stampPipe[DLY-1];
  assign lnk.rxSopLaneIndex = state_r.lanePipe[DLY-1];
  assign lnk.laneFill = state_r.fill;
  assign lnk.laneStatusPinMap = state_r.pinMap;
  assign lnk.laneMapError = state_r.mapError;
  assign lnk.txReady = (state_r.txState == rpt_pkg::TX_IDLE);
  assign lnk.txStampValid = state_r.txStampValid;
  assign lnk.txStamp = state_r.txStamp;
  assign lnk.txStampTag = state_r.txStampTag;
  assign txDropped = state_r.txDropped;

endmodule

// ---- logic/rpt_link_if.sv ----
// Link between the timestamp capture end and the user packet logic.
interface rpt_link_if;
  logic [rpt_pkg::TIME_W-1:0] sysTime;
  logic rxSop;
  logic [rpt_pkg::TIME_W-1:0] rxStamp;
  logic [rpt_pkg::LANE_W-1:0] rxSopLaneIndex;
  logic [rpt_pkg::MAX_LANES-1:0][rpt_pkg::FILL_W-1:0] laneFill;
  logic [rpt_pkg::MAX_LANES-1:0][rpt_pkg::LANE_W-1:0] laneStatusPinMap;
  logic laneMapError;
  logic txSop;
  logic txPtp;
  logic [rpt_pkg::TAG_W-1:0] txTag;
  logic txReady;
  logic txStampValid;
  logic [rpt_pkg::TIME_W-1:0] txStamp;
  logic [rpt_pkg::TAG_W-1:0] txStampTag;

  modport dev
  (
    input sysTime, txSop, txPtp, txTag,
    output rxSop, rxStamp, rxSopLaneIndex, laneFill, laneStatusPinMap,
    output laneMapError, txReady, txStampValid, txStamp, txStampTag
  );

  modport usr
  (
    output sysTime, txSop, txPtp, txTag,
    input rxSop, rxStamp, rxSopLaneIndex, laneFill, laneStatusPinMap,
    input laneMapError, txReady, txStampValid, txStamp, txStampTag
  );
endinterface

// ---- logic/rpt_pkg.sv ----
// Shared widths, timing figures and types for the receive timestamp pair.
package rpt_pkg;
  localparam int TIME_W = 80;
  localparam int TAG_W = 16;
  localparam int LANE_W = 2;
  localparam int MAX_LANES = 4;
  localparam int LANES_40G = 2;
  localparam int LANES_50G = 4;
  localparam int FILL_W = 6;
  localparam int STREAM_DLY = 2;
  localparam int REF_LANE = 0;
  localparam int FRAC_W = 16;
  localparam int AVG_SH = 4;
  localparam int AVG_W = FILL_W + AVG_SH;
  localparam int CORR_W = 48;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [TIME_W-1:0] CYCLE_STEP =
    TIME_W'(CLK_PERIOD_NS) << FRAC_W;
  localparam logic signed [CORR_W-1:0] CYCLE_STEP_CORR =
    CORR_W'(CLK_PERIOD_NS) << FRAC_W;

  typedef enum logic
  {
    TX_IDLE = 1'b0,
    TX_PEND = 1'b1
  } rpt_tx_state_type;
endpackage

// ---- logic/rpt_usr_end.sv ----
// User end: drives system time and corrects receive stamps for skew.
module rpt_usr_end #(
  parameter int LANES = rpt_pkg::LANES_50G,
  parameter int REF_LANE = rpt_pkg::REF_LANE
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link to the capture end
  rpt_link_if.usr lnk,
  // Transmit requests
  input wire logic userTxSop,
  input wire logic userTxPtp,
  input wire logic [rpt_pkg::TAG_W-1:0] userTxTag,
  output logic userTxReady,
  // Corrected receive stamps
  output logic corrSop,
  output logic [rpt_pkg::TIME_W-1:0] corrStamp,
  // Returned transmit stamps
  output logic txRetValid,
  output logic [rpt_pkg::TIME_W-1:0] txRetStamp,
  output logic [rpt_pkg::TAG_W-1:0] txRetTag
);

  typedef struct packed
  {
    logic [rpt_pkg::TIME_W-1:0] sysTime;
    logic [rpt_pkg::MAX_LANES-1:0][rpt_pkg::AVG_W-1:0] avgFill;
    logic corrSop;
    logic [rpt_pkg::TIME_W-1:0] corrStamp;
    logic txRetValid;
    logic [rpt_pkg::TIME_W-1:0] txRetStamp;
    logic [rpt_pkg::TAG_W-1:0] txRetTag;
  } rpt_usr_state_type;

  rpt_usr_state_type state_r;
  rpt_usr_state_type state_nxt;
  logic signed [rpt_pkg::AVG_W:0] fillDiff;
  logic signed [rpt_pkg::CORR_W-1:0] corrProd;

  // First-order average with AVG_SH fraction bits.
  function automatic logic [rpt_pkg::AVG_W-1:0] rpt_avg_step(
    input logic [rpt_pkg::AVG_W-1:0] avg,
    input logic [rpt_pkg::FILL_W-1:0] fill
  );
    logic signed [rpt_pkg::AVG_W:0] delta;
    delta = $signed({1'b0, fill, {rpt_pkg::AVG_SH{1'b0}}})
      - $signed({1'b0, avg});
    return avg + rpt_pkg::AVG_W'(delta >>> rpt_pkg::AVG_SH);
  endfunction

  always_comb
  begin
    state_nxt = state_r;
    // The time base runs on the capture clock, so it needs no retiming.
    // Capture-domain time base
    state_nxt.sysTime = state_r.sysTime + rpt_pkg::CYCLE_STEP;

    // Averaging hides the one-cycle quantisation wobble of the fills.
    // Time-averaged fills
    for (int i = 0; i < LANES; i++)
    begin
      state_nxt.avgFill[i] = rpt_avg_step(state_r.avgFill[i],
        lnk.laneFill[i]);
    end

    fillDiff = $signed({1'b0, state_r.avgFill[lnk.rxSopLaneIndex]})
      - $signed({1'b0, state_r.avgFill[REF_LANE]});
    corrProd = rpt_pkg::CORR_W'(fillDiff) * rpt_pkg::CYCLE_STEP_CORR;

    state_nxt.corrSop = lnk.rxSop;
    if (lnk.rxSop)
    begin
      state_nxt.corrStamp = lnk.rxStamp
        + rpt_pkg::TIME_W'(corrProd >>> rpt_pkg::AVG_SH);
    end

    state_nxt.txRetValid = lnk.txStampValid;
    if (lnk.txStampValid)
    begin
      state_nxt.txRetStamp = lnk.txStamp;
      state_nxt.txRetTag = lnk.txStampTag;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign lnk.sysTime = state_r.sysTime;
  assign lnk.txSop = userTxSop;
  assign lnk.txPtp = userTxPtp;
  assign lnk.txTag = userTxTag;
  assign userTxReady = lnk.txReady;
  assign corrSop = state_r.corrSop;
  assign corrStamp = state_r.corrStamp;
  assign txRetValid = state_r.txRetValid;
  assign txRetStamp = state_r.txRetStamp;
  assign txRetTag = state_r.txRetTag;

endmodule

// ---- tb/rpt_link_properties.sv ----
// Interface checks for the receive timestamp pair.
module rpt_link_properties
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link signals
  input wire logic [rpt_pkg::TIME_W-1:0] sysTime,
  input wire logic rxSop,
  input wire logic [rpt_pkg::TIME_W-1:0] rxStamp,
  input wire logic txSop,
  input wire logic txPtp,
  input wire logic [rpt_pkg::TAG_W-1:0] txTag,
  input wire logic txReady,
  input wire logic txStampValid,
  input wire logic [rpt_pkg::TIME_W-1:0] txStamp,
  input wire logic [rpt_pkg::TAG_W-1:0] txStampTag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [rpt_pkg::TAG_W-1:0] tagHold_r;
  logic mark;
  assign mark = txSop && txPtp && txReady;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // The tag of an accepted mark must come back with its stamp.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      tagHold_r <= '0;
    else if (mark)
      tagHold_r <= txTag;
  end
  a_time_step: assert property (
    $past(rst_n) |-> sysTime == $past(sysTime) + rpt_pkg::CYCLE_STEP)
    else $error("system time did not step");
  a_rx_time: assert property (
    rxSop |-> rxStamp == $past(sysTime, 2))
    else $error("receive stamp wrong");
  a_ready_fall: assert property (
    mark |=> !txReady)
    else $error("ready stayed high after mark");
  a_ready_back: assert property (
    txStampValid |-> txReady && !$past(txReady))
    else $error("ready wrong around stamp");
  a_tx_time: assert property (
    txStampValid |-> txStamp == $past(sysTime))
    else $error("transmit stamp wrong");
  a_tx_tag: assert property (
    txStampValid |-> txStampTag == tagHold_r)
    else $error("transmit tag wrong");
  a_valid_pulse: assert property (
    txStampValid |=> !txStampValid)
    else $error("stamp valid too long");
  a_stamp_hold: assert property (
    !txStampValid |-> $stable(txStamp) && $stable(txStampTag))
    else $error("transmit stamp not held");
  c_rx: cover property (rxSop);
  c_tx: cover property (txStampValid);
  c_drop: cover property (txSop && txPtp && !txReady);
endmodule

// ---- tb/rpt_tb.sv ----
// Self-checking testbench for the receive timestamp pair.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [79:0] STEP = rpt_pkg::CYCLE_STEP;
  // One sixteenth of a cycle of time per sixteenth of a fill cycle.
  localparam longint K =
    (rpt_pkg::CLK_PERIOD_NS << rpt_pkg::FRAC_W) >>> rpt_pkg::AVG_SH;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic lineRxSop, lineTxSop, userTxSop, userTxPtp;
  logic txDropped, userTxReady, corrSop, txRetValid;
  logic [1:0] lineRxLane;
  logic [3:0][5:0] lineFill;
  logic [3:0][1:0] linePinMap;
  logic [15:0] userTxTag, txRetTag;
  logic [79:0] corrStamp, txRetStamp;
  int n_errors = 0;
  int compares = 0;
  int tk = 0;
  int cyc = 0;
  rpt_link_if lnk ();
  rpt_dev_end i_rpt_dev_end (.sys_clk(sys_clk), .rst_n(rst_n), .lnk(lnk),
    .lineRxSop(lineRxSop), .lineRxLane(lineRxLane), .lineFill(lineFill),
    .linePinMap(linePinMap), .lineTxSop(lineTxSop), .txDropped(txDropped));
  rpt_usr_end i_rpt_usr_end (.sys_clk(sys_clk), .rst_n(rst_n), .lnk(lnk),
    .userTxSop(userTxSop), .userTxPtp(userTxPtp), .userTxTag(userTxTag),
    .userTxReady(userTxReady), .corrSop(corrSop), .corrStamp(corrStamp),
    .txRetValid(txRetValid), .txRetStamp(txRetStamp), .txRetTag(txRetTag));
  rpt_link_properties i_rpt_link_properties (.sys_clk(sys_clk),
    .rst_n(rst_n), .sysTime(lnk.sysTime), .rxSop(lnk.rxSop),
    .rxStamp(lnk.rxStamp), .txSop(lnk.txSop), .txPtp(lnk.txPtp),
    .txTag(lnk.txTag), .txReady(lnk.txReady),
    .txStampValid(lnk.txStampValid), .txStamp(lnk.txStamp),
    .txStampTag(lnk.txStampTag));
  always #5 sys_clk = ~sys_clk;
  // tk counts edges since reset release, cyc since time zero; a hang to edge 2000 of cyc ends the run as a mismatch.
  always @(posedge sys_clk)
  begin
    tk <= rst_n ? tk + 1 : 0;
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_errors++;
      summarize();
    end
  end
  task cmp(input logic [79:0] got, input logic [79:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("Comparisons %0d, errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task do_reset;
    @(negedge sys_clk);
    rst_n = 0;
    repeat (4) @(negedge sys_clk);
    rst_n = 1;
    cmp(txDropped, 0);
    cmp(userTxReady, 1);
  endtask
  // Converged fill average; fills stay constant so the path is fixed.
  function automatic int avgOf(input int f);
    int a;
    a = 0;
    repeat (200) a += ((f << rpt_pkg::AVG_SH) - a) >>> rpt_pkg::AVG_SH;
    return a;
  endfunction
  // Four back-to-back receive starts, one on each lane.
  // The stamp is the time standing when the start is sampled; it leaves
  // the capture end two edges later and the user end one edge after that.
  task t_rx;
    logic [79:0] e [4];
    longint d;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge sys_clk);
      lineRxSop = (i < 4);
      lineRxLane = 2'(i);
      if (i < 4)
        e[i] = 80'(tk) * STEP;
      if (i >= 2 && i < 6)
      begin
        cmp(lnk.rxSop, 1);
        cmp(lnk.rxStamp, e[i-2]);
        cmp(lnk.rxSopLaneIndex, i - 2);
      end
      if (i >= 3 && i < 7)
      begin
        d = avgOf(lineFill[i-3]) - avgOf(lineFill[0]);
        cmp(corrSop, 1);
        cmp(corrStamp, e[i-3] + 80'(d * K));
      end
    end
    cmp(lnk.rxSop, 0);
    cmp(corrSop, 0);
  endtask
  task t_map;
    @(negedge sys_clk);
    linePinMap = {2'h1, 2'h3, 2'h0, 2'h2};
    @(negedge sys_clk);
    cmp(lnk.laneStatusPinMap, linePinMap);
    cmp(lnk.laneMapError, 0);
    cmp(lnk.laneFill, lineFill);
    linePinMap = {2'h1, 2'h1, 2'h0, 2'h2};
    @(negedge sys_clk);
    cmp(lnk.laneMapError, 1);
  endtask
  // Unmarked start, marked start, refused second mark, then the stamp.
  task t_tx(input logic [15:0] tag);
    logic [79:0] e;
    @(negedge sys_clk);
    userTxSop = 1;
    userTxPtp = 0;
    @(negedge sys_clk);
    cmp(userTxReady, 1);
    userTxPtp = 1;
    userTxTag = tag;
    @(negedge sys_clk);
    cmp(userTxReady, 0);
    userTxTag = ~tag;
    @(negedge sys_clk);
    userTxSop = 0;
    cmp(txDropped, 1);
    lineTxSop = 1;
    e = 80'(tk) * STEP;
    @(negedge sys_clk);
    cmp(lnk.txStampValid, 1);
    cmp(lnk.txStamp, e);
    cmp(lnk.txStampTag, tag);
    cmp(userTxReady, 1);
    @(negedge sys_clk);
    cmp(txRetValid, 1);
    cmp(txRetStamp, e);
    cmp(txRetTag, tag);
    @(negedge sys_clk);
    lineTxSop = 0;
    cmp(lnk.txStampValid, 0);
  endtask
  initial
  begin
    lineRxSop = 0;
    lineRxLane = 0;
    lineTxSop = 0;
    lineFill = {6'h05, 6'h21, 6'h14, 6'h08};
    linePinMap = {2'h3, 2'h2, 2'h1, 2'h0};
    userTxSop = 0;
    userTxPtp = 0;
    userTxTag = 0;
    do_reset();
    repeat (300) @(negedge sys_clk);
    t_rx();
    t_map();
    t_tx(16'h5a3c);
    do_reset();
    t_tx(16'hc3a5);
    summarize();
  end
endmodule
